// *** design/proc_ctrl_regs.svh ***
// Functional notes
// - pin reset restores every register default
// - fetch starts at FF00 after 200 us
// - usb reset touches only C090 and C0B0
// - one 64K byte space for everything
// - registers C000-C0FF, boot rom E000-FFFF
// - chip selects idle on internal accesses
// - ram merge maps 4000-BFFF to external ram
// - C100-DFFF selects external rom window
// - external address reaches 512 KB via paging
// - flags read-only, bit 4 global interrupt enable
// - bit 3 is result msb
// - bit 2 is arithmetic overflow
// - bit 1 is carry or borrow
// - bit 0 set on zero result
// - general register address from bank and index
// - bank base resets to 0100
// - read-only revision register at C004
// - nine registers decoded, diagnostics write-only
// - decode independent of access direction
// - speed field divides processor clock only
`ifndef PROC_CTRL_REGS_SVH
`define PROC_CTRL_REGS_SVH
`define REG_FLAGS 16'hC000
`define REG_BANK 16'hC002
`define REG_REV 16'hC004
`define REG_SPEED 16'hC008
`define REG_POWER 16'hC00A
`define REG_IRQEN 16'hC00E
`define REG_BRK 16'hC014
`define REG_USBDIAG 16'hC03C
`define REG_MEMDIAG 16'hC03E
`define BANK_RESET 16'h0100
`define BANK_MASK 16'hFFF0
`define SPEED_RESET 16'h000F
`define SPEED_MASK 16'h000F
`define POWER_MASK 16'hFB93
`define POWER_BOOST_BIT 2
`define FLAG_GIE_BIT 4
`define FLAG_NEG_BIT 3
`define FLAG_OVF_BIT 2
`define FLAG_CARRY_BIT 1
`define FLAG_ZERO_BIT 0
`define XRAM_LO 16'h4000
`define XRAM_HI 16'hBFFF
`define REGS_LO 16'hC000
`define REGS_HI 16'hC0FF
`define XROM_LO 16'hC100
`define XROM_HI 16'hDFFF
`define BOOT_ENTRY 16'hE000
`define RESET_VEC 16'hFF00
`define CLK_PERIOD_NS 10
`define RST_MIN_NS 1300
`define RST_MIN_CYC ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BOOT_DELAY_US 200
`define BOOT_DELAY_CYC (`BOOT_DELAY_US * 1000 / `CLK_PERIOD_NS)
`endif

// *** design/proc_ctrl_pkg.sv ***
package proc_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_LOW = 4'h2,
    ST_HELD = 4'h4,
    ST_BOOT = 4'h8
  } rst_state_t;
endpackage : proc_ctrl_pkg

// *** design/reset_sequencer.sv ***
`timescale 1ns/100ps
`include "proc_ctrl_regs.svh"
module reset_sequencer #(
  parameter int BOOT_CYC = `BOOT_DELAY_CYC
) (
  input wire logic mclk, // system clock
  input wire logic reset, // async power-on reset
  input wire logic ce, // clock enable
  input wire logic reset_in_n, // reset pin, asynchronous
  output logic soft_rst, // registers held at defaults
  output logic cpu_hold, // processor stopped
  output logic cpu_start // one-cycle fetch start
);
  localparam int CW = $clog2(BOOT_CYC + `RST_MIN_CYC + 1);
  logic [2:0] sync_reg;
  proc_ctrl_pkg::rst_state_t st_reg, st_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic start_next;
  logic hold_next;
  logic pin_low, pin_high;

  assign pin_low = ~sync_reg[1] & ~sync_reg[2];
  assign pin_high = sync_reg[1] & sync_reg[2];

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    start_next = 1'b0;
    case (st_reg)
      proc_ctrl_pkg::ST_RUN: begin
        if (pin_low) begin
          st_next = proc_ctrl_pkg::ST_LOW;
          cnt_next = CW'(1);
        end
      end
      proc_ctrl_pkg::ST_LOW: begin
        if (pin_high && cpu_hold) begin
          // a short low during the boot wait restarts the wait, never frees the processor
          st_next = proc_ctrl_pkg::ST_BOOT;
          cnt_next = '0;
        end else if (pin_high) begin
          st_next = proc_ctrl_pkg::ST_RUN;
        end else if (pin_low && cnt_reg == CW'(`RST_MIN_CYC - 1)) begin
          st_next = proc_ctrl_pkg::ST_HELD;
        end else if (pin_low) begin
          cnt_next = CW'(cnt_reg + 1'b1);
        end
      end
      proc_ctrl_pkg::ST_HELD: begin
        if (pin_high) begin
          st_next = proc_ctrl_pkg::ST_BOOT;
          cnt_next = '0;
        end
      end
      default: begin
        if (pin_low) begin
          st_next = proc_ctrl_pkg::ST_LOW;
          cnt_next = CW'(1);
        end else if (cnt_reg == CW'(BOOT_CYC - 1)) begin
          st_next = proc_ctrl_pkg::ST_RUN;
          start_next = 1'b1;
        end else begin
          cnt_next = CW'(cnt_reg + 1'b1);
        end
      end
    endcase
    hold_next = (st_next == proc_ctrl_pkg::ST_HELD) || (st_next == proc_ctrl_pkg::ST_BOOT) ||
      ((st_next == proc_ctrl_pkg::ST_LOW) && cpu_hold);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync_reg <= 3'h7;
      st_reg <= proc_ctrl_pkg::ST_BOOT;
      cnt_reg <= '0;
      soft_rst <= 1'b0;
      cpu_hold <= 1'b1;
      cpu_start <= 1'b0;
    end else if (ce) begin
      sync_reg <= {sync_reg[1:0], reset_in_n};
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      soft_rst <= (st_next == proc_ctrl_pkg::ST_HELD);
      cpu_hold <= hold_next;
      cpu_start <= start_next;
    end
  end

  property p_start_on_release;
    @(posedge mclk) disable iff (reset) $fell(cpu_hold) |-> cpu_start;
  endproperty
  a_start_on_release: assert property (p_start_on_release) else $error("hold fell without start");
  property p_hold_in_rst;
    @(posedge mclk) disable iff (reset) soft_rst |-> cpu_hold && !cpu_start;
  endproperty
  a_hold_in_rst: assert property (p_hold_in_rst) else $error("cpu ran during reset");
  c_pin_reset: cover property (@(posedge mclk) disable iff (reset) $rose(soft_rst));
  c_boot_done: cover property (@(posedge mclk) disable iff (reset) cpu_start);
endmodule : reset_sequencer

// *** design/cpu_clock_divider.sv ***
`timescale 1ns/100ps
module cpu_clock_divider (
  input wire logic mclk, // system clock
  input wire logic reset, // async reset
  input wire logic ce, // clock enable
  input wire logic [3:0] div, // divide by div+1
  output logic tick // processor clock enable
);
  logic [3:0] cnt_reg, cnt_next;
  logic tick_next;

  always_comb begin
    tick_next = (cnt_reg >= div);
    cnt_next = tick_next ? 4'h0 : 4'(cnt_reg + 1'b1);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 4'h0;
      tick <= 1'b0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end

  // helper: cycles since the last tick, valid while div unchanged
  logic [4:0] gap_reg;
  logic seen_reg;
  logic [3:0] div_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gap_reg <= 5'h00;
      seen_reg <= 1'b0;
      div_q <= 4'h0;
    end else if (ce) begin
      gap_reg <= tick ? 5'h00 : 5'(gap_reg + 1'b1);
      seen_reg <= (tick || seen_reg) && (div == div_q);
      div_q <= div;
    end
  end
  property p_div_period;
    @(posedge mclk) disable iff (reset)
      (ce && tick && seen_reg && $stable(div)) |-> gap_reg == 5'(div);
  endproperty
  a_div_period: assert property (p_div_period) else $error("wrong processor divide");
endmodule : cpu_clock_divider

// *** design/processor_control_regs.sv ***
`timescale 1ns/100ps
`include "proc_ctrl_regs.svh"
module processor_control_regs #(
  parameter int BOOT_CYC = `BOOT_DELAY_CYC,
  parameter int EXT_AW = 19,
  parameter logic [15:0] REVISION = 16'h0003 // arbitrary value
) (
  input wire logic mclk, // 100 MHz system clock
  input wire logic reset, // async power-on reset
  input wire logic ce, // clock enable
  input wire logic reset_in_n, // reset pin
  input wire logic usb_reset, // usb bus reset pulse
  input wire logic [15:0] cpu_addr, // processor byte address
  input wire logic cpu_rd, // read strobe
  input wire logic cpu_wr, // write strobe
  input wire logic [15:0] cpu_wdata, // write data
  input wire logic ram_merge, // external ram window on
  input wire logic [EXT_AW-17:0] ext_page, // upper external address
  input wire logic alu_update, // flag-affecting instruction done
  input wire logic [15:0] alu_result, // its result
  input wire logic alu_carry, // carry or borrow
  input wire logic alu_overflow, // signed overflow
  input wire logic global_int_en, // global interrupts enabled
  input wire logic [3:0] gen_reg_index, // general register number
  input wire logic boost_not_ok, // boost rail low
  output logic [15:0] cpu_rdata, // register read data
  output logic ext_ram_select_n, // external ram select
  output logic ext_rom_select_n, // external rom select
  output logic [EXT_AW-1:0] ext_addr, // external byte address
  output logic sel_int_ram, // internal ram access
  output logic sel_regs, // control register access
  output logic sel_boot_rom, // boot rom access
  output logic [15:0] gen_reg_addr, // ram address of general register
  output logic cpu_clk_en, // divided processor clock enable
  output logic cpu_hold, // processor stopped
  output logic cpu_start, // fetch start pulse
  output logic [15:0] start_addr, // first fetch address
  output logic usb_reinit, // reinit of usb-reset registers
  output logic [15:0] irq_enable, // interrupt enable mask
  output logic [15:0] breakpoint, // breakpoint address
  output logic [15:0] power_ctrl, // power and wakeup control
  output logic [15:0] usb_diag, // usb diagnostic control
  output logic [15:0] mem_diag // memory diagnostic control
);
  logic soft_rst;
  logic [4:0] flags_reg, flags_next;
  logic [15:0] bank_reg, bank_next;
  logic [15:0] speed_reg, speed_next;
  logic [15:0] irqen_next, brk_next, power_next, udiag_next, mdiag_next;
  logic [15:0] rdata_next, gaddr_next;
  logic ram_n_next, rom_n_next, iram_next, regs_next, brom_next;
  logic [EXT_AW-1:0] eaddr_next;
  logic req;

  reset_sequencer #(.BOOT_CYC(BOOT_CYC)) u_rst (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .reset_in_n(reset_in_n),
    .soft_rst(soft_rst),
    .cpu_hold(cpu_hold),
    .cpu_start(cpu_start)
  );

  cpu_clock_divider u_div (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .div(speed_reg[3:0]),
    .tick(cpu_clk_en)
  );

  assign req = cpu_rd | cpu_wr;

  // address decode of the full 64K byte space
  always_comb begin
    ram_n_next = 1'b1;
    rom_n_next = 1'b1;
    iram_next = 1'b0;
    regs_next = 1'b0;
    brom_next = 1'b0;
    eaddr_next = ext_addr;
    if (!req) begin
      eaddr_next = ext_addr;
    end else if (cpu_addr >= `BOOT_ENTRY) begin
      brom_next = 1'b1;
    end else if (cpu_addr >= `XROM_LO && cpu_addr <= `XROM_HI) begin
      rom_n_next = 1'b0;
      eaddr_next = {ext_page, cpu_addr};
    end else if (cpu_addr >= `REGS_LO && cpu_addr <= `REGS_HI) begin
      regs_next = 1'b1;
    end else if (ram_merge && cpu_addr >= `XRAM_LO && cpu_addr <= `XRAM_HI) begin
      ram_n_next = 1'b0;
      eaddr_next = {ext_page, cpu_addr};
    end else begin
      iram_next = 1'b1;
    end
  end

  // register writes, pin reset defaults and flag capture
  always_comb begin
    flags_next = flags_reg;
    bank_next = bank_reg;
    speed_next = speed_reg;
    irqen_next = irq_enable;
    brk_next = breakpoint;
    power_next = power_ctrl;
    udiag_next = usb_diag;
    mdiag_next = mem_diag;
    flags_next[`FLAG_GIE_BIT] = global_int_en;
    if (alu_update) begin
      flags_next[`FLAG_NEG_BIT] = alu_result[15];
      flags_next[`FLAG_OVF_BIT] = alu_overflow;
      flags_next[`FLAG_CARRY_BIT] = alu_carry;
      flags_next[`FLAG_ZERO_BIT] = (alu_result == 16'h0000);
    end
    if (cpu_wr) begin
      if (cpu_addr == `REG_BANK) begin
        bank_next = cpu_wdata & `BANK_MASK;
      end else if (cpu_addr == `REG_SPEED) begin
        speed_next = cpu_wdata & `SPEED_MASK;
      end else if (cpu_addr == `REG_POWER) begin
        power_next = cpu_wdata & `POWER_MASK;
      end else if (cpu_addr == `REG_IRQEN) begin
        irqen_next = cpu_wdata;
      end else if (cpu_addr == `REG_BRK) begin
        brk_next = cpu_wdata;
      end else if (cpu_addr == `REG_USBDIAG) begin
        udiag_next = cpu_wdata;
      end else if (cpu_addr == `REG_MEMDIAG) begin
        mdiag_next = cpu_wdata;
      end
    end
    power_next[`POWER_BOOST_BIT] = boost_not_ok;
    if (soft_rst) begin
      flags_next = 5'h00;
      bank_next = `BANK_RESET;
      speed_next = `SPEED_RESET;
      irqen_next = 16'h0000;
      brk_next = 16'h0000;
      power_next = 16'h0000;
      udiag_next = 16'h0000;
      mdiag_next = 16'h0000;
    end
  end

  // read mux; write-only and unmapped addresses read zero
  always_comb begin
    rdata_next = cpu_rdata;
    if (cpu_rd) begin
      if (cpu_addr == `REG_FLAGS) begin
        rdata_next = {11'h000, flags_reg};
      end else if (cpu_addr == `REG_BANK) begin
        rdata_next = bank_reg;
      end else if (cpu_addr == `REG_REV) begin
        rdata_next = REVISION;
      end else if (cpu_addr == `REG_SPEED) begin
        rdata_next = speed_reg;
      end else if (cpu_addr == `REG_POWER) begin
        rdata_next = power_ctrl;
      end else if (cpu_addr == `REG_IRQEN) begin
        rdata_next = irq_enable;
      end else if (cpu_addr == `REG_BRK) begin
        rdata_next = breakpoint;
      end else begin
        rdata_next = 16'h0000;
      end
    end
    gaddr_next = (bank_reg & `BANK_MASK) | {11'h000, gen_reg_index, 1'b0};
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flags_reg <= 5'h00;
      bank_reg <= `BANK_RESET;
      speed_reg <= `SPEED_RESET;
      irq_enable <= 16'h0000;
      breakpoint <= 16'h0000;
      power_ctrl <= 16'h0000;
      usb_diag <= 16'h0000;
      mem_diag <= 16'h0000;
      cpu_rdata <= 16'h0000;
      gen_reg_addr <= `BANK_RESET;
      ext_ram_select_n <= 1'b1;
      ext_rom_select_n <= 1'b1;
      ext_addr <= '0;
      sel_int_ram <= 1'b0;
      sel_regs <= 1'b0;
      sel_boot_rom <= 1'b0;
      start_addr <= `RESET_VEC;
      usb_reinit <= 1'b0;
    end else if (ce) begin
      flags_reg <= flags_next;
      bank_reg <= bank_next;
      speed_reg <= speed_next;
      irq_enable <= irqen_next;
      breakpoint <= brk_next;
      power_ctrl <= power_next;
      usb_diag <= udiag_next;
      mem_diag <= mdiag_next;
      cpu_rdata <= rdata_next;
      gen_reg_addr <= gaddr_next;
      ext_ram_select_n <= ram_n_next;
      ext_rom_select_n <= rom_n_next;
      ext_addr <= eaddr_next;
      sel_int_ram <= iram_next;
      sel_regs <= regs_next;
      sel_boot_rom <= brom_next;
      start_addr <= `RESET_VEC;
      usb_reinit <= usb_reset;
    end
  end

  property p_ext_ram;
    @(posedge mclk) disable iff (reset)
      (ce && req && ram_merge && cpu_addr >= `XRAM_LO && cpu_addr <= `XRAM_HI)
      |=> !ext_ram_select_n && ext_rom_select_n;
  endproperty
  a_ext_ram: assert property (p_ext_ram) else $error("ram select missing");
  property p_ext_rom;
    @(posedge mclk) disable iff (reset)
      (ce && req && cpu_addr >= `XROM_LO && cpu_addr <= `XROM_HI)
      |=> !ext_rom_select_n && ext_ram_select_n;
  endproperty
  a_ext_rom: assert property (p_ext_rom) else $error("rom select missing");
  property p_cs_internal;
    @(posedge mclk) disable iff (reset)
      (sel_int_ram || sel_regs || sel_boot_rom) |-> ext_ram_select_n && ext_rom_select_n;
  endproperty
  a_cs_internal: assert property (p_cs_internal) else $error("select on internal");
  property p_bank_default;
    @(posedge mclk) disable iff (reset) (ce && soft_rst) |=> bank_reg == `BANK_RESET;
  endproperty
  a_bank_default: assert property (p_bank_default) else $error("bank not restored");
  property p_gen_addr;
    @(posedge mclk) disable iff (reset)
      (ce && bank_reg == `BANK_RESET && gen_reg_index == 4'hE) |=> gen_reg_addr == 16'h011C;
  endproperty
  a_gen_addr: assert property (p_gen_addr) else $error("bad register address");
  property p_zero_flag;
    @(posedge mclk) disable iff (reset)
      (ce && !soft_rst && alu_update) |=> flags_reg[0] == ($past(alu_result) == 16'h0000);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");
  property p_flags_hold;
    @(posedge mclk) disable iff (reset)
      (ce && !soft_rst && !alu_update) |=> $stable(flags_reg[3:0]);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags moved");
  property p_rev_read;
    @(posedge mclk) disable iff (reset) (ce && cpu_rd && cpu_addr == `REG_REV) |=> cpu_rdata == REVISION;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision read wrong");
  property p_diag_wo;
    @(posedge mclk) disable iff (reset)
      (ce && cpu_rd && (cpu_addr == `REG_USBDIAG || cpu_addr == `REG_MEMDIAG)) |=> cpu_rdata == 16'h0000;
  endproperty
  a_diag_wo: assert property (p_diag_wo) else $error("diagnostic readable");
  property p_usb_keep;
    @(posedge mclk) disable iff (reset)
      (ce && usb_reset && !cpu_wr && !soft_rst) |=> $stable(bank_reg) && $stable(speed_reg);
  endproperty
  a_usb_keep: assert property (p_usb_keep) else $error("usb reset hit register");
  property p_gie_flag;
    @(posedge mclk) disable iff (reset)
      (ce && !soft_rst) |=> flags_reg[`FLAG_GIE_BIT] == $past(global_int_en);
  endproperty
  a_gie_flag: assert property (p_gie_flag) else $error("interrupt flag wrong");
  property p_neg_flag;
    @(posedge mclk) disable iff (reset)
      (ce && !soft_rst && alu_update) |=> flags_reg[`FLAG_NEG_BIT] == $past(alu_result[15]);
  endproperty
  a_neg_flag: assert property (p_neg_flag) else $error("negative flag wrong");
  property p_ovf_flag;
    @(posedge mclk) disable iff (reset)
      (ce && !soft_rst && alu_update) |=> flags_reg[`FLAG_OVF_BIT] == $past(alu_overflow);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag wrong");
  property p_carry_flag;
    @(posedge mclk) disable iff (reset)
      (ce && !soft_rst && alu_update) |=> flags_reg[`FLAG_CARRY_BIT] == $past(alu_carry);
  endproperty
  a_carry_flag: assert property (p_carry_flag) else $error("carry flag wrong");
  property p_bank_write;
    @(posedge mclk) disable iff (reset) (ce && !soft_rst && cpu_wr && cpu_addr == `REG_BANK)
      |=> bank_reg == ($past(cpu_wdata) & `BANK_MASK);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank write wrong");
  property p_usb_reinit;
    @(posedge mclk) disable iff (reset)
      ce |=> usb_reinit == $past(usb_reset);
  endproperty
  a_usb_reinit: assert property (p_usb_reinit) else $error("usb reinit missing");
  property p_boot_sel;
    @(posedge mclk) disable iff (reset) (ce && req && cpu_addr >= `BOOT_ENTRY)
      |=> sel_boot_rom && ext_ram_select_n && ext_rom_select_n;
  endproperty
  a_boot_sel: assert property (p_boot_sel) else $error("boot rom not selected");
  property p_regs_sel;
    @(posedge mclk) disable iff (reset) (ce && req && cpu_addr >= `REGS_LO && cpu_addr <= `REGS_HI)
      |=> sel_regs && !sel_int_ram && ext_ram_select_n && ext_rom_select_n;
  endproperty
  a_regs_sel: assert property (p_regs_sel) else $error("registers not selected");
  property p_int_ram;
    @(posedge mclk) disable iff (reset) (ce && req && cpu_addr < `XRAM_LO)
      |=> sel_int_ram && ext_ram_select_n && ext_rom_select_n;
  endproperty
  a_int_ram: assert property (p_int_ram) else $error("internal ram not selected");
  c_ram_access: cover property (@(posedge mclk) disable iff (reset) !ext_ram_select_n);
  c_rom_access: cover property (@(posedge mclk) disable iff (reset) !ext_rom_select_n);
  c_div_write: cover property (@(posedge mclk) disable iff (reset) cpu_wr && cpu_addr == `REG_SPEED);
endmodule : processor_control_regs

// *** bench/test_processor_control_regs.sv ***
`timescale 1ns/100ps
`include "proc_ctrl_regs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_processor_control_regs;
  localparam int BOOT = 20;
  localparam logic [15:0] REV = 16'h0007; // arbitrary value
  logic mclk, reset, ce, reset_in_n, usb_reset, cpu_rd, cpu_wr, ram_merge;
  logic alu_update, alu_carry, alu_overflow, global_int_en, boost_not_ok;
  logic [15:0] cpu_addr, cpu_wdata, alu_result;
  logic [2:0] ext_page;
  logic [3:0] gen_reg_index;
  logic [15:0] cpu_rdata, gen_reg_addr, start_addr, irq_enable, breakpoint;
  logic [15:0] power_ctrl, usb_diag, mem_diag;
  logic [18:0] ext_addr;
  logic ext_ram_select_n, ext_rom_select_n, sel_int_ram, sel_regs, sel_boot_rom;
  logic cpu_clk_en, cpu_hold, cpu_start, usb_reinit;
  int miscompares, checks, n;
  // decode table: address, merge, expected {int, regs, boot, ram_n, rom_n}
  logic [15:0] dec_a [12] = '{16'h0000, 16'h3FFF, 16'h4000, 16'hBFFF, 16'h4000, 16'hBFFF,
    16'hC000, 16'hC0FF, 16'hC100, 16'hDFFF, 16'hE000, 16'hFFFF};
  logic dec_m [12] = '{1, 1, 1, 1, 0, 0, 1, 1, 1, 1, 1, 1};
  logic [4:0] dec_e [12] = '{5'h13, 5'h13, 5'h01, 5'h01, 5'h13, 5'h13,
    5'h0B, 5'h0B, 5'h02, 5'h02, 5'h07, 5'h07};

  processor_control_regs #(.BOOT_CYC(BOOT), .EXT_AW(19), .REVISION(REV)) dut (
    .mclk(mclk), .reset(reset), .ce(ce), .reset_in_n(reset_in_n), .usb_reset(usb_reset),
    .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata),
    .ram_merge(ram_merge), .ext_page(ext_page), .alu_update(alu_update),
    .alu_result(alu_result), .alu_carry(alu_carry), .alu_overflow(alu_overflow),
    .global_int_en(global_int_en), .gen_reg_index(gen_reg_index),
    .boost_not_ok(boost_not_ok), .cpu_rdata(cpu_rdata),
    .ext_ram_select_n(ext_ram_select_n), .ext_rom_select_n(ext_rom_select_n),
    .ext_addr(ext_addr), .sel_int_ram(sel_int_ram), .sel_regs(sel_regs),
    .sel_boot_rom(sel_boot_rom), .gen_reg_addr(gen_reg_addr), .cpu_clk_en(cpu_clk_en),
    .cpu_hold(cpu_hold), .cpu_start(cpu_start), .start_addr(start_addr),
    .usb_reinit(usb_reinit), .irq_enable(irq_enable), .breakpoint(breakpoint),
    .power_ctrl(power_ctrl), .usb_diag(usb_diag), .mem_diag(mem_diag)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  // strobe stays up across the taking edge; caller checks, then releases
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_rd = ~w;
    cpu_wr = w;
    cyc(1);
  endtask : acc

  task automatic idle();
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cyc(1);
  endtask : idle

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
    idle();
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    `CHK(cpu_rdata, e)
    idle();
  endtask : rd

  task automatic wait_start();
    n = 0;
    while (cpu_start !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    `CHK(cpu_start, 1'b1)
    `CHK(start_addr, `RESET_VEC)
    cyc(1);
    `CHK(cpu_hold, 1'b0)
  endtask : wait_start

  task automatic summarize();
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    summarize();
  end

  initial begin
    reset = 1'b1; ce = 1'b1; reset_in_n = 1'b1; usb_reset = 1'b0; cpu_rd = 1'b0;
    cpu_wr = 1'b0; ram_merge = 1'b1; alu_update = 1'b0; alu_carry = 1'b0;
    alu_overflow = 1'b0; global_int_en = 1'b0; boost_not_ok = 1'b0;
    cpu_addr = 16'h0000; cpu_wdata = 16'h0000; alu_result = 16'h0000;
    ext_page = 3'h5; gen_reg_index = 4'hE;
    miscompares = 0;
    checks = 0;
    cyc(8);
    reset = 1'b0;
    `CHK(cpu_hold, 1'b1)
    wait_start();
    // defaults and access kinds
    rd(`REG_BANK, `BANK_RESET);
    `CHK(gen_reg_addr, 16'h011C)
    rd(`REG_REV, REV);
    rd(`REG_SPEED, 16'h000F);
    rd(`REG_IRQEN, 16'h0000);
    rd(`REG_BRK, 16'h0000);
    boost_not_ok = 1'b1;
    cyc(2);
    rd(`REG_POWER, 16'h0004);
    wr(`REG_POWER, 16'hFB93);
    rd(`REG_POWER, 16'hFB97);
    `CHK(power_ctrl, 16'hFB97)
    wr(`REG_REV, 16'hFFFF);
    rd(`REG_REV, REV);
    wr(`REG_BANK, 16'h1230);
    rd(`REG_BANK, 16'h1230);
    gen_reg_index = 4'h3;
    cyc(2);
    `CHK(gen_reg_addr, 16'h1236)
    wr(`REG_IRQEN, 16'hA55A);
    `CHK(irq_enable, 16'hA55A)
    rd(`REG_IRQEN, 16'hA55A);
    wr(`REG_BRK, 16'h3C3C);
    rd(`REG_BRK, 16'h3C3C);
    `CHK(breakpoint, 16'h3C3C)
    wr(`REG_USBDIAG, 16'h1111);
    wr(`REG_MEMDIAG, 16'h2222);
    `CHK(usb_diag, 16'h1111)
    `CHK(mem_diag, 16'h2222)
    rd(`REG_USBDIAG, 16'h0000);
    rd(`REG_MEMDIAG, 16'h0000);
    // flags from arithmetic results
    global_int_en = 1'b1;
    alu_result = 16'h8000; alu_carry = 1'b1; alu_overflow = 1'b1; alu_update = 1'b1;
    cyc(1);
    alu_update = 1'b0;
    cyc(1);
    rd(`REG_FLAGS, 16'h001E);
    alu_result = 16'h0000; alu_carry = 1'b0; alu_overflow = 1'b0; alu_update = 1'b1;
    cyc(1);
    alu_update = 1'b0;
    alu_result = 16'h8001;
    cyc(1);
    rd(`REG_FLAGS, 16'h0011);
    global_int_en = 1'b0;
    cyc(2);
    wr(`REG_FLAGS, 16'h001F);
    rd(`REG_FLAGS, 16'h0001);
    // address decode for every region
    for (int i = 0; i < 12; i++) begin
      ram_merge = dec_m[i];
      acc(1'b0, dec_a[i], 16'h0000);
      `CHK({sel_int_ram, sel_regs, sel_boot_rom, ext_ram_select_n, ext_rom_select_n},
        dec_e[i])
      if (dec_e[i][1:0] != 2'b11) begin
        `CHK(ext_addr, {ext_page, dec_a[i]})
      end
      idle();
    end
    // processor clock divider, divide by four
    wr(`REG_SPEED, 16'h0003);
    rd(`REG_SPEED, 16'h0003);
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    n = 0;
    cyc(1);
    while (cpu_clk_en !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    `CHK(n + 1, 4)
    // usb bus reset leaves the bank register alone
    usb_reset = 1'b1;
    cyc(1);
    usb_reset = 1'b0;
    `CHK(usb_reinit, 1'b1)
    cyc(1);
    `CHK(usb_reinit, 1'b0)
    rd(`REG_BANK, 16'h1230);
    // clock enable low freezes the bank register
    ce = 1'b0;
    wr(`REG_BANK, 16'h5670);
    ce = 1'b1;
    rd(`REG_BANK, 16'h1230);
    // short pin pulse is ignored
    reset_in_n = 1'b0;
    cyc(20);
    reset_in_n = 1'b1;
    cyc(8);
    `CHK(cpu_hold, 1'b0)
    rd(`REG_BANK, 16'h1230);
    // long pin pulse restores defaults and reboots
    reset_in_n = 1'b0;
    cyc(150);
    `CHK(cpu_hold, 1'b1)
    reset_in_n = 1'b1;
    cyc(5);
    wait_start();
    rd(`REG_BANK, `BANK_RESET);
    rd(`REG_IRQEN, 16'h0000);
    rd(`REG_BRK, 16'h0000);
    rd(`REG_SPEED, 16'h000F);
    `CHK(usb_diag, 16'h0000)
    summarize();
  end
endmodule : test_processor_control_regs
